// *** core/mcc_defs.svh ***
// Offsets, field positions, reset values and codes of the MAC command and configuration word.
// Assumes inclusion by bare name from the package and the core module only.
`ifndef MCC_DEFS_SVH
`define MCC_DEFS_SVH

// Printed offsets are word indices; the byte address is four times the index.
`define MCC_CFG_INDEX 6'h02
`define MCC_CFG_RESET 32'h0000_0000
// Bit 11 is status and is held apart, so it is outside the writable mask.
`define MCC_CFG_WR_MASK 32'h0007_27FF
`define MCC_RD_UNMAPPED 32'h0000_0000

`define MCC_BIT_TX_EN 0
`define MCC_BIT_RX_EN 1
`define MCC_BIT_ZERO_PAUSE 2
`define MCC_BIT_SPEED 3
`define MCC_BIT_ACCEPT_ALL 4
`define MCC_BIT_STRIP_PAD 5
`define MCC_BIT_PASS_FCS 6
`define MCC_BIT_FWD_FLOW 7
`define MCC_BIT_IGNORE_PAUSE 8
`define MCC_BIT_INSERT_SA 9
`define MCC_BIT_HALF_DUP 10
`define MCC_BIT_TOO_MANY_COLLISIONS_FLAG 11
`define MCC_BIT_SOFT_RST 13
`define MCC_SA_SEL_LO 16
`define MCC_SA_SEL_HI 18

// Source address select codes: 3'h0 is the primary, 3'h4 and up the supplementaries.
`define MCC_SA_SEL_PRIMARY 3'h0
`define MCC_SA_SEL_SUPP_FLAG 2

`endif

// *** core/mcc_pkg.sv ***
// Types shared by the command and configuration word logic.
// Assumes the constants header sits beside it in core/.
package mcc_pkg;
  `include "mcc_defs.svh"

  typedef enum logic [1:0] {
    MCC_SR_IDLE = 2'b00,
    MCC_SR_DRAIN = 2'b01,
    MCC_SR_DONE = 2'b11
  } mcc_srst_e;

  typedef struct packed {
    logic tx_path_enable;
    logic rx_path_enable;
    logic zero_pause_frame_request;
    logic accept_all_frames;
    logic strip_pad;
    logic strip_fcs;
    logic forward_flow_frames;
    logic obey_pause;
    logic insert_source_address;
    logic sa_supplementary;
    logic [1:0] sa_supp_index;
    logic half_duplex_select;
  } mcc_ctrl_s;
endpackage

// *** core/mcc_command_config.sv ***
// Command and configuration word of a 10/100/1000 Ethernet MAC with its register slave.
// Assumes one system clock, a synchronous active-low reset, and datapaths on the same
// clock that report frame activity; the gigabit-select pin is asynchronous.
`include "mcc_defs.svh"

// Function
// - Bit 0 enables transmit; zero after reset or soft reset.
// - Bit 1 enables receive; zero after reset or soft reset.
// - Bit 2 requests a zero-quanta pause frame regardless of FIFO fill.
// - Speed bit high forces gigabit and masks the gigabit-select pin.
// - Speed bit low: gigabit only while the pin is high, else 10/100.
// - Gigabit-mode indicator high exactly while running at gigabit rate.
// - Bit 4 accepts every frame without destination filtering.
// - Bit 5 strips receive padding; transmit unaffected.
// - Bit 6 high passes received FCS, low strips it.
// - Padded frame with pad removal: FCS checked and stripped anyway.
// - Bit 7 high forwards received pause frames, low discards them.
// - Bit 8 low obeys received pause frames, high ignores them.
// - Bit 9 replaces transmit source address with the selected station address.
// - Bit 10 picks half duplex; ignored while speed bit is high.
// - Excess-collision flag sets on 16-attempt discard, clears on reset, and on soft reset unless a collision comes in its last cycle.
// - Soft reset drains frames, disables paths, flushes, clears counters and itself.
// - Select 000 primary, 100 to 111 supplementary zero to three.
module mcc_command_config (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_gigabit_select,
  input wire logic i_tx_frame_busy,
  input wire logic i_rx_frame_busy,
  input wire logic i_rx_frame_padded,
  input wire logic i_excess_collision,
  output mcc_pkg::mcc_ctrl_s o_ctrl,
  output logic o_gigabit_mode,
  output logic o_rx_fifo_flush,
  output logic o_stats_clear
);
  import mcc_pkg::*;

  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic [31:0] be_mask;
  logic [31:0] rd_word;
  logic wait_q;
  logic hit;
  logic wr_take;
  logic rd_first;
  logic excess_q;
  logic gsel_meta_q;
  logic gsel_q;
  logic tx_en_q;
  logic rx_en_q;
  logic [2:0] sa_sel;
  mcc_srst_e srst_q;
  mcc_srst_e srst_d;
  mcc_ctrl_s ctrl_q;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_be
      assign be_mask[8*g +: 8] = {8{i_byteenable[g]}};
    end
  endgenerate

  assign hit = (i_address[7:2] == `MCC_CFG_INDEX);
  // A write lands only on the edge where the master sees waitrequest low.
  assign wr_take = i_write && !wait_q && hit;
  assign rd_first = i_read && wait_q;
  assign sa_sel = cfg_q[`MCC_SA_SEL_HI:`MCC_SA_SEL_LO];

  always_comb begin
    rd_word = cfg_q;
    rd_word[`MCC_BIT_TOO_MANY_COLLISIONS_FLAG] = excess_q;
  end

  // Every access is answered after exactly one wait cycle.
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      wait_q <= 1'b1;
    end else if ((i_read || i_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Read data is captured early so it already stands when waitrequest drops.
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_readdata <= `MCC_RD_UNMAPPED;
    end else if (rd_first) begin
      o_readdata <= hit ? rd_word : `MCC_RD_UNMAPPED;
    end
  end

  always_comb begin
    cfg_d = cfg_q;
    if (wr_take) begin
      cfg_d = ((cfg_q & ~be_mask) | (i_writedata & be_mask)) & `MCC_CFG_WR_MASK;
    end
    if (srst_q == MCC_SR_DONE) begin
      cfg_d[`MCC_BIT_TX_EN] = 1'b0;
      cfg_d[`MCC_BIT_RX_EN] = 1'b0;
      cfg_d[`MCC_BIT_SOFT_RST] = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      cfg_q <= `MCC_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_comb begin
    srst_d = srst_q;
    unique case (srst_q)
      MCC_SR_IDLE: begin
        if (cfg_q[`MCC_BIT_SOFT_RST]) begin
          srst_d = MCC_SR_DRAIN;
        end
      end
      MCC_SR_DRAIN: begin
        // Frames in flight are allowed to finish before the paths shut down.
        if (!i_tx_frame_busy && !i_rx_frame_busy) begin
          srst_d = MCC_SR_DONE;
        end
      end
      MCC_SR_DONE: begin
        srst_d = MCC_SR_IDLE;
      end
      default: begin
        srst_d = MCC_SR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      srst_q <= MCC_SR_IDLE;
    end else begin
      srst_q <= srst_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_rx_fifo_flush <= 1'b0;
      o_stats_clear <= 1'b0;
    end else begin
      o_rx_fifo_flush <= (srst_q == MCC_SR_DONE);
      o_stats_clear <= (srst_q == MCC_SR_DONE);
    end
  end

  // A collision event in the same cycle as the soft reset end keeps the flag set.
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      excess_q <= 1'b0;
    end else if (i_excess_collision) begin
      excess_q <= 1'b1;
    end else if (srst_q == MCC_SR_DONE) begin
      excess_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      gsel_meta_q <= 1'b0;
      gsel_q <= 1'b0;
    end else begin
      gsel_meta_q <= i_gigabit_select;
      gsel_q <= gsel_meta_q;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_gigabit_mode <= 1'b0;
    end else begin
      o_gigabit_mode <= cfg_q[`MCC_BIT_SPEED] || gsel_q;
    end
  end

  // The effective enables follow the register only while the path is idle, so a
  // frame is never cut short; during a soft reset they drop as each path drains.
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      tx_en_q <= 1'b0;
    end else if (!i_tx_frame_busy) begin
      tx_en_q <= cfg_q[`MCC_BIT_TX_EN] && (srst_q == MCC_SR_IDLE);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      rx_en_q <= 1'b0;
    end else if (!i_rx_frame_busy) begin
      rx_en_q <= cfg_q[`MCC_BIT_RX_EN] && (srst_q == MCC_SR_IDLE);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      // Reset leaves pause frames obeyed and the check sequence stripped, as the
      // cleared word asks, so the datapaths never see a state the word cannot hold.
      ctrl_q <= '0;
      ctrl_q.obey_pause <= 1'b1;
      ctrl_q.strip_fcs <= 1'b1;
    end else begin
      ctrl_q.zero_pause_frame_request <= cfg_q[`MCC_BIT_ZERO_PAUSE];
      ctrl_q.accept_all_frames <= cfg_q[`MCC_BIT_ACCEPT_ALL];
      ctrl_q.strip_pad <= cfg_q[`MCC_BIT_STRIP_PAD];
      // Pad removal on a padded frame overrides the forward choice.
      ctrl_q.strip_fcs <= !cfg_q[`MCC_BIT_PASS_FCS] ||
        (cfg_q[`MCC_BIT_STRIP_PAD] && i_rx_frame_padded);
      ctrl_q.forward_flow_frames <= cfg_q[`MCC_BIT_FWD_FLOW];
      ctrl_q.obey_pause <= !cfg_q[`MCC_BIT_IGNORE_PAUSE];
      ctrl_q.insert_source_address <= cfg_q[`MCC_BIT_INSERT_SA];
      // Codes 001 to 011 are undefined and fall back to the primary address.
      ctrl_q.sa_supplementary <= sa_sel[`MCC_SA_SEL_SUPP_FLAG];
      ctrl_q.sa_supp_index <= sa_sel[`MCC_SA_SEL_SUPP_FLAG] ? sa_sel[1:0] : 2'h0;
      ctrl_q.half_duplex_select <= cfg_q[`MCC_BIT_HALF_DUP] &&
        !cfg_q[`MCC_BIT_SPEED];
    end
  end

  always_comb begin
    o_ctrl = ctrl_q;
    o_ctrl.tx_path_enable = tx_en_q;
    o_ctrl.rx_path_enable = rx_en_q;
  end

  assign o_waitrequest = wait_q;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  bus_one_wait_a: assert property ((i_read || i_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("Access not answered after exactly one wait cycle.");
  tx_frame_hold_a: assert property (i_tx_frame_busy |=> $stable(o_ctrl.tx_path_enable))
    else $error("Transmit enable changed inside a frame.");
  rx_frame_hold_a: assert property (i_rx_frame_busy |=> $stable(o_ctrl.rx_path_enable))
    else $error("Receive enable changed inside a frame.");
  tx_clear_done_a: assert property (srst_q == MCC_SR_DONE |=> !cfg_q[`MCC_BIT_TX_EN])
    else $error("Transmit enable survived soft reset.");
  rx_clear_done_a: assert property (srst_q == MCC_SR_DONE |=> !cfg_q[`MCC_BIT_RX_EN])
    else $error("Receive enable survived soft reset.");
  // Soft reset runs request, drain while frames finish, then one clearing cycle.
  srst_wait_a: assert property (
    srst_q == MCC_SR_DRAIN && (i_tx_frame_busy || i_rx_frame_busy) |=> srst_q == MCC_SR_DRAIN)
    else $error("Soft reset finished while a frame was active.");
  srst_start_a: assert property (
    srst_q == MCC_SR_IDLE && cfg_q[`MCC_BIT_SOFT_RST] |=> srst_q == MCC_SR_DRAIN)
    else $error("Soft reset request did not start the drain.");
  srst_finish_a: assert property (
    srst_q == MCC_SR_DRAIN && !i_tx_frame_busy && !i_rx_frame_busy |=> srst_q == MCC_SR_DONE)
    else $error("Soft reset stalled with both paths idle.");
  srst_effects_a: assert property (
    srst_q == MCC_SR_DONE |=> o_rx_fifo_flush && o_stats_clear && !cfg_q[`MCC_BIT_SOFT_RST]
    ##1 !o_rx_fifo_flush)
    else $error("Soft reset end did not flush, clear counters and self-clear once.");

  // Each control output other than the path enables follows its word bits, the synchronised select pin or the padded-frame input one cycle later.
  zero_pause_a: assert property (
    cfg_q[`MCC_BIT_ZERO_PAUSE] |=> o_ctrl.zero_pause_frame_request)
    else $error("Zero pause request not driven.");
  zero_pause_off_a: assert property (
    !cfg_q[`MCC_BIT_ZERO_PAUSE] |=> !o_ctrl.zero_pause_frame_request)
    else $error("Zero pause request driven while its bit is clear.");
  speed_force_a: assert property (cfg_q[`MCC_BIT_SPEED] |=> o_gigabit_mode)
    else $error("Speed bit did not force gigabit mode.");
  speed_pin_a: assert property (
    !cfg_q[`MCC_BIT_SPEED] |=> o_gigabit_mode == $past(gsel_q))
    else $error("Gigabit mode does not follow the synchronised select pin.");
  gig_indicator_a: assert property (
    o_gigabit_mode == $past(cfg_q[`MCC_BIT_SPEED] || gsel_q))
    else $error("Gigabit indicator disagrees with operating rate.");
  accept_all_a: assert property (
    o_ctrl.accept_all_frames == $past(cfg_q[`MCC_BIT_ACCEPT_ALL]))
    else $error("Accept-all control does not follow its bit.");
  strip_pad_a: assert property (o_ctrl.strip_pad == $past(cfg_q[`MCC_BIT_STRIP_PAD]))
    else $error("Pad strip control does not follow its bit.");
  fcs_pass_a: assert property (!cfg_q[`MCC_BIT_STRIP_PAD] |=>
    o_ctrl.strip_fcs == !$past(cfg_q[`MCC_BIT_PASS_FCS]))
    else $error("FCS strip control wrong without pad removal.");
  pad_fcs_a: assert property (
    cfg_q[`MCC_BIT_STRIP_PAD] && i_rx_frame_padded |=> o_ctrl.strip_fcs)
    else $error("Padded frame kept its FCS under pad removal.");
  flow_fwd_a: assert property (
    o_ctrl.forward_flow_frames == $past(cfg_q[`MCC_BIT_FWD_FLOW]))
    else $error("Pause forward control does not follow its bit.");
  obey_pause_a: assert property (
    o_ctrl.obey_pause != $past(cfg_q[`MCC_BIT_IGNORE_PAUSE]))
    else $error("Pause obey control not the inverse of its bit.");
  insert_sa_a: assert property (
    o_ctrl.insert_source_address == $past(cfg_q[`MCC_BIT_INSERT_SA]))
    else $error("Source insert control does not follow its bit.");
  half_dup_a: assert property (cfg_q[`MCC_BIT_SPEED] |=> !o_ctrl.half_duplex_select)
    else $error("Half duplex selected while speed bit forces gigabit.");
  half_dup_follow_a: assert property (
    !cfg_q[`MCC_BIT_SPEED] |=> o_ctrl.half_duplex_select == $past(cfg_q[`MCC_BIT_HALF_DUP]))
    else $error("Half duplex control does not follow its bit.");
  sa_sel_a: assert property (sa_sel[2] |=> o_ctrl.sa_supplementary &&
    o_ctrl.sa_supp_index == $past(sa_sel[1:0]))
    else $error("Supplementary address index wrong.");

  excess_set_a: assert property (
    i_excess_collision |=> excess_q ##1 excess_q || $past(srst_q) == MCC_SR_DONE)
    else $error("Excess collision flag not set or lost.");
  excess_clear_a: assert property (
    srst_q == MCC_SR_DONE && !i_excess_collision |=> !excess_q)
    else $error("Excess collision flag survived soft reset.");
  excess_read_a: assert property (
    i_read && !wait_q && hit |-> o_readdata[`MCC_BIT_TOO_MANY_COLLISIONS_FLAG] == $past(excess_q))
    else $error("Read word does not carry the excess collision flag.");

  // Read data are captured one cycle early, so they are judged against that cycle's word.
  cfg_readback_a: assert property (i_read && !wait_q && hit |->
    (o_readdata & `MCC_CFG_WR_MASK) == ($past(cfg_q) & `MCC_CFG_WR_MASK))
    else $error("Read word does not match the stored configuration.");
  rd_unmapped_a: assert property (i_read && !wait_q && !hit |-> o_readdata == `MCC_RD_UNMAPPED)
    else $error("Unmapped read returned a nonzero word.");
  cfg_write_a: assert property (wr_take && i_byteenable == 4'hF && srst_q != MCC_SR_DONE |=>
    cfg_q == ($past(i_writedata) & `MCC_CFG_WR_MASK))
    else $error("Full-lane write did not land with reserved bits cleared.");

  cfg_write_c: cover property (wr_take);
  cfg_read_c: cover property (i_read && !wait_q && hit);
  srst_drain_c: cover property (srst_q == MCC_SR_DRAIN && i_tx_frame_busy
    ##[1:20] srst_q == MCC_SR_DONE);
  gig_pin_c: cover property (!cfg_q[`MCC_BIT_SPEED] && o_gigabit_mode);
  pad_strip_c: cover property (cfg_q[`MCC_BIT_STRIP_PAD] && cfg_q[`MCC_BIT_PASS_FCS] &&
    i_rx_frame_padded);
endmodule // mcc_command_config

// *** bench/mcc_frame_model.sv ***
// Behavioural transmit and receive datapaths beside the control word.
// Assumes the system clock of the design; every frame lasts twelve cycles.
module mcc_frame_model
  import mcc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire mcc_pkg::mcc_ctrl_s i_ctrl,
  input wire logic i_tx_go,
  input wire logic i_rx_go,
  input wire logic i_pad,
  output logic o_tx_busy,
  output logic o_rx_busy,
  output logic o_padded
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] tx_cnt_q = 4'h0;
  logic [3:0] rx_cnt_q = 4'h0;
  logic pad_q = 1'b0;
  logic run;
  // A start request on either path is dropped unless both paths are enabled, as the real MAC would.
  assign run = i_ctrl.tx_path_enable && i_ctrl.rx_path_enable;
  always_ff @(posedge i_clk_sys) begin
    if (tx_cnt_q != 4'h0) tx_cnt_q <= tx_cnt_q - 4'h1;
    else if (i_tx_go && run) tx_cnt_q <= 4'hC;
  end
  always_ff @(posedge i_clk_sys) begin
    if (rx_cnt_q != 4'h0) rx_cnt_q <= rx_cnt_q - 4'h1;
    else if (i_rx_go && run) rx_cnt_q <= 4'hC;
    if (rx_cnt_q == 4'h0) pad_q <= i_pad;
  end
  assign o_tx_busy = tx_cnt_q != 4'h0;
  assign o_rx_busy = rx_cnt_q != 4'h0;
  assign o_padded = o_rx_busy && pad_q;
endmodule // mcc_frame_model

// *** bench/tb_mcc_command_config.sv ***
// Self-checking bench for the MAC command and configuration word.
// Assumes the design in core/ and the frame model in bench/.
module tb_mcc_command_config;
  import mcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdata;
  logic wreq;
  logic gsel = 1'b0;
  logic txgo = 1'b0;
  logic rxgo = 1'b0;
  logic pad = 1'b0;
  logic excol = 1'b0;
  logic txb;
  logic rxb;
  logic padd;
  logic gm;
  logic flush;
  logic sclr;
  mcc_ctrl_s ctrl;
  int bad_count = 0;
  int checked = 0;

  mcc_command_config mcc_command_config_i (.i_clk_sys(clk), .i_nrst(nrst), .i_address(addr),
    .i_read(rd), .i_write(wr), .i_byteenable(be), .i_writedata(wd), .o_readdata(rdata),
    .o_waitrequest(wreq), .i_gigabit_select(gsel), .i_tx_frame_busy(txb),
    .i_rx_frame_busy(rxb), .i_rx_frame_padded(padd), .i_excess_collision(excol),
    .o_ctrl(ctrl), .o_gigabit_mode(gm), .o_rx_fifo_flush(flush), .o_stats_clear(sclr));
  mcc_frame_model mcc_frame_model_i (.i_clk_sys(clk), .i_ctrl(ctrl), .i_tx_go(txgo),
    .i_rx_go(rxgo), .i_pad(pad), .o_tx_busy(txb), .o_rx_busy(rxb), .o_padded(padd));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // The request stays up until waitrequest is seen low, for at most 50 cycles before the bench gives up and concludes.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n = 0;
    addr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) begin
      bad_count++;
      conclude();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wreg(input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, 8'h08, d, q);
  endtask

  task automatic rchk(input string n, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, 8'h08, 32'h0000_0000, q);
    chk(n, e, q);
  endtask

  task automatic busy_wait();
    int n = 0;
    while ((txb !== 1'b0 || rxb !== 1'b0) && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      conclude();
    end
  endtask

  function automatic mcc_ctrl_s exp_ctrl(input logic [31:0] c, input logic p);
    mcc_ctrl_s e;
    e.tx_path_enable = c[0];
    e.rx_path_enable = c[1];
    e.zero_pause_frame_request = c[2];
    e.accept_all_frames = c[4];
    e.strip_pad = c[5];
    e.strip_fcs = !c[6] || (c[5] && p);
    e.forward_flow_frames = c[7];
    e.obey_pause = !c[8];
    e.insert_source_address = c[9];
    e.sa_supplementary = c[18];
    e.sa_supp_index = c[18] ? c[17:16] : 2'h0;
    e.half_duplex_select = c[10] && !c[3];
    return e;
  endfunction

  task automatic t_reset();
    tick(2);
    chk("path enables", 32'h0, 32'({ctrl.tx_path_enable, ctrl.rx_path_enable}));
    chk("gigabit", 32'h0, 32'(gm));
    rchk("cfg reset", 32'h0);
  endtask

  // Reserved bits ride along in the first word; 011 stands for the undefined select codes.
  task automatic t_fields();
    logic [31:0] w [6] = '{32'hFFF8_D7F4, 32'h0004_0418, 32'h0005_0228, 32'h0006_0500,
                           32'h0007_0094, 32'h0003_0000};
    foreach (w[i]) begin
      wreg(w[i]);
      tick(3);
      chk("ctrl", 32'(exp_ctrl(w[i], 1'b0)), 32'(ctrl));
      rchk("cfg", w[i] & 32'h0007_27FF);
    end
  endtask

  task automatic t_speed();
    for (int i = 0; i < 4; i++) begin
      wreg({28'h0, i[1], 3'h0});
      gsel <= i[0];
      tick(6);
      chk("gigabit", 32'(i[1] | i[0]), 32'(gm));
    end
    gsel <= 1'b0;
  endtask

  task automatic t_fcs();
    wreg(32'h0000_0060);
    wreg(32'h0000_0063);
    tick(2);
    pad <= 1'b1;
    rxgo <= 1'b1;
    @(posedge clk);
    rxgo <= 1'b0;
    pad <= 1'b0;
    tick(3);
    chk("strip fcs padded", 32'h1, 32'(ctrl.strip_fcs));
    busy_wait();
    tick(3);
    chk("strip fcs plain", 32'h0, 32'(ctrl.strip_fcs));
  endtask

  task automatic t_gate();
    txgo <= 1'b1;
    @(posedge clk);
    txgo <= 1'b0;
    wreg(32'h0000_0000);
    tick(1);
    chk("tx enable in frame", 32'h1, 32'(ctrl.tx_path_enable));
    chk("rx enable idle", 32'h0, 32'(ctrl.rx_path_enable));
    busy_wait();
    tick(3);
    chk("tx enable after", 32'h0, 32'(ctrl.tx_path_enable));
  endtask

  task automatic t_srst();
    int f = 0;
    int s = 0;
    int e = 0;
    wreg(32'h0000_0003);
    tick(2);
    excol <= 1'b1;
    rxgo <= 1'b1;
    txgo <= 1'b1;
    @(posedge clk);
    excol <= 1'b0;
    rxgo <= 1'b0;
    txgo <= 1'b0;
    rchk("collision flag", 32'h0000_0803);
    wreg(32'h0000_2003);
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      f += flush;
      s += sclr;
      e += flush & (rxb | txb);
    end
    chk("flush pulses", 32'h1, 32'(f));
    chk("stats pulses", 32'h1, 32'(s));
    chk("flush in frame", 32'h0, 32'(e));
    chk("path enables", 32'h0, 32'({ctrl.tx_path_enable, ctrl.rx_path_enable}));
    rchk("cfg after soft reset", 32'h0);
  endtask

  task automatic t_unmap();
    logic [31:0] q;
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF, q);
    bus(1'b0, 8'h0C, 32'h0000_0000, q);
    chk("unmapped read", 32'h0, q);
    rchk("cfg untouched", 32'h0);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_fields();
    t_speed();
    t_fcs();
    t_gate();
    t_srst();
    t_unmap();
    conclude();
  end
endmodule // tb_mcc_command_config
